// ==== hdl/tio_top.sv ====
`timescale 1ns/100ps
module tio_top #(
    parameter int RTC_CYCLES = tio_pkg::RTC_CYCLES
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic [15:0]         bus_addr,
    input  wire logic                bus_io,
    input  wire logic                bus_inta,
    input  wire logic [7:0]          bus_wdata,
    input  wire logic                bus_wr,
    input  wire logic                bus_rd,
    output logic      [7:0]          bus_rdata,
    output logic                     irq,
    output logic                     cpu_hold,
    output logic      [3:0]          baud_sel,
    output tio_pkg::tio_ext_type     ext_cmd,
    input  wire logic [7:0]          ext_rdata,
    input  wire logic [7:0]          kbd_data,
    input  wire logic                kbd_strobe,
    input  wire logic                xcvr_rx_ready,
    input  wire logic                xcvr_tx_empty,
    input  wire logic                external_interrupt_request_n,
    input  wire logic                dma_hold_req
);
    typedef struct packed {
        logic [tio_pkg::SY_N-1:0]  s1;
        logic [tio_pkg::SY_N-1:0]  s2;
        logic [tio_pkg::SY_N-1:0]  prv;
        logic [7:0]                ctrl;
        logic [7:0]                kbd;
        logic [7:0]                kd1;
        logic [7:0]                kd2;
        logic [tio_pkg::IRQ_N-1:0] status;
        logic                      irq;
        logic                      hold;
        logic                      started;
        tio_pkg::tio_ext_type      ext;
    } tio_state_type;

    tio_state_type st_r;
    tio_state_type st_nxt;
    logic [1:0]    rst_sync_r;
    logic          rst_core_n;
    logic          rtc_done;
    logic          rtc_trig;
    logic          ram_hit;
    logic          ram_we;
    logic [7:0]    bypass;

    // reset released through two flops
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync_r <= 2'b00;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_r[1];

    // decode and status next state
    always_comb
    begin
        logic                      is_rd;
        logic                      is_wr;
        logic [7:0]                port;
        logic [tio_pkg::SY_N-1:0]  rise;
        logic [tio_pkg::IRQ_N-1:0] set;
        logic [tio_pkg::IRQ_N-1:0] clr;
        tio_pkg::tio_sel_type      sel;
        is_rd    = bus_rd && !bus_inta;
        is_wr    = bus_wr;
        port     = bus_addr[7:0];
        rise     = st_r.s2 & ~st_r.prv;
        set      = '0;
        clr      = '0;
        sel      = tio_pkg::SEL_NONE;
        ram_hit  = 1'b0;
        bypass   = 8'h00;
        rtc_trig = 1'b0;
        st_nxt   = st_r;
        // pin inputs pass two flops before use
        st_nxt.s1  = {dma_hold_req, external_interrupt_request_n,
                      xcvr_tx_empty, xcvr_rx_ready, kbd_strobe};
        st_nxt.s2  = st_r.s1;
        st_nxt.prv = st_r.s2;
        // keyboard bus follows the strobe through two flops
        st_nxt.kd1 = kbd_data;
        st_nxt.kd2 = st_r.kd1;
        st_nxt.ext.rd = 1'b0;
        st_nxt.ext.wr = 1'b0;
        if (bus_io)
        begin
            if (port == tio_pkg::PORT_XCVR)
            begin
                sel = tio_pkg::SEL_XCVR;
            end
            else if (port == tio_pkg::PORT_PANEL)
            begin
                sel = tio_pkg::SEL_PANEL;
            end
            else if (port >= tio_pkg::PORT_BP_LO && port <= tio_pkg::PORT_BP_HI)
            begin
                sel = tio_pkg::SEL_BPPORT;
            end
        end
        else
        begin
            if (bus_addr <= tio_pkg::ROM_END)
            begin
                sel = tio_pkg::SEL_ROM;
            end
            else if (bus_addr >= tio_pkg::EROM_BASE && bus_addr <= tio_pkg::EROM_END)
            begin
                sel = tio_pkg::SEL_EROM;
            end
            else if (bus_addr >= tio_pkg::RAM_BASE && bus_addr <= tio_pkg::RAM_END)
            begin
                ram_hit = bus_rd && !bus_inta;
            end
            else
            begin
                sel = tio_pkg::SEL_BPMEM;
            end
        end
        // off-board strobes, one cycle after the request
        if ((is_rd || is_wr) && sel != tio_pkg::SEL_NONE)
        begin
            st_nxt.ext.sel   = sel;
            st_nxt.ext.rd    = is_rd;
            st_nxt.ext.wr    = is_wr;
            st_nxt.ext.addr  = bus_addr;
            st_nxt.ext.wdata = bus_wdata;
        end
        // read data for everything but on-board ram
        if (bus_rd && bus_inta)
        begin
            bypass = tio_pkg::VEC_OPCODE;
        end
        else if (bus_io && port == tio_pkg::PORT_CTRL)
        begin
            bypass = 8'(st_r.status);
        end
        else if (bus_io && port == tio_pkg::PORT_KBD)
        begin
            bypass = st_r.kbd;
        end
        else if (sel != tio_pkg::SEL_NONE)
        begin
            bypass = ext_rdata;
        end
        if (is_wr && bus_io && port == tio_pkg::PORT_CTRL)
        begin
            st_nxt.ctrl = bus_wdata;
        end
        if (is_wr && bus_io && port == tio_pkg::PORT_CLR)
        begin
            clr = bus_wdata[tio_pkg::IRQ_N-1:0];
        end
        if (is_rd && bus_io && port == tio_pkg::PORT_XCVR)
        begin
            clr[tio_pkg::IRQ_RX] = 1'b1;
        end
        if (is_wr && bus_io && port == tio_pkg::PORT_XCVR)
        begin
            clr[tio_pkg::IRQ_TX] = 1'b1;
        end
        if (is_rd && bus_io && port == tio_pkg::PORT_KBD)
        begin
            clr[tio_pkg::IRQ_KBD] = 1'b1;
        end
        if (rise[tio_pkg::SY_KBD])
        begin
            st_nxt.kbd = st_r.kd2;
        end
        set[tio_pkg::IRQ_RX]  = rise[tio_pkg::SY_RX];
        set[tio_pkg::IRQ_TX]  = rise[tio_pkg::SY_TX];
        set[tio_pkg::IRQ_KBD] = rise[tio_pkg::SY_KBD];
        set[tio_pkg::IRQ_RTC] = rtc_done;
        set[tio_pkg::IRQ_EXT] = !st_r.s2[tio_pkg::SY_EXTN];
        // set wins over clear
        st_nxt.status = (st_r.status & ~clr) | set;
        // one-shot armed at start and on clear of its bit
        st_nxt.started = 1'b1;
        rtc_trig = !st_r.started || clr[tio_pkg::IRQ_RTC];
        st_nxt.irq = |(st_r.status[tio_pkg::EN_W-1:0] & st_r.ctrl[tio_pkg::EN_W-1:0])
                   || st_r.status[tio_pkg::IRQ_EXT];
        st_nxt.hold = st_r.s2[tio_pkg::SY_HOLD];
    end

    assign ram_we = bus_wr && !bus_io && bus_addr >= tio_pkg::RAM_BASE
                    && bus_addr <= tio_pkg::RAM_END;

    // state register
    always_ff @(posedge core_clk or negedge rst_core_n)
    begin
        if (!rst_core_n)
        begin
            st_r         <= '0;
            st_r.s1      <= tio_pkg::SY_RST;
            st_r.s2      <= tio_pkg::SY_RST;
            st_r.prv     <= tio_pkg::SY_RST;
            st_r.ctrl    <= tio_pkg::CTRL_RST;
            st_r.ext.sel <= tio_pkg::SEL_NONE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // on-board ram; its read register also carries all other read data
    tio_ram #(
        .AW    (tio_pkg::RAM_AW),
        .DEPTH (tio_pkg::RAM_BYTES)
    ) u_ram (
        .core_clk (core_clk),
        .we       (ram_we),
        .hit      (ram_hit),
        .addr     (bus_addr[tio_pkg::RAM_AW-1:0]),
        .wdata    (bus_wdata),
        .bypass   (bypass),
        .rdata_r  (bus_rdata)
    );

    // real-time clock one-shot
    tio_rtc #(
        .CYCLES (RTC_CYCLES),
        .CW     (tio_pkg::RTC_CNT_W)
    ) u_rtc (
        .core_clk (core_clk),
        .rst_n    (rst_core_n),
        .trig     (rtc_trig),
        .done_r   (rtc_done)
    );

    // outputs straight from state flops
    assign irq      = st_r.irq;
    assign cpu_hold = st_r.hold;
    assign baud_sel = st_r.ctrl[tio_pkg::BAUD_LSB +: tio_pkg::BAUD_W];
    assign ext_cmd  = st_r.ext;
endmodule : tio_top

// ==== hdl/tio_pkg.sv ====
package tio_pkg;
    // processor bus widths
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 16;
    // io port numbers
    localparam logic [7:0] PORT_XCVR  = 8'h00;
    localparam logic [7:0] PORT_CTRL  = 8'h01;
    localparam logic [7:0] PORT_KBD   = 8'h02;
    localparam logic [7:0] PORT_PANEL = 8'h03;
    localparam logic [7:0] PORT_BP_LO = 8'h04;
    localparam logic [7:0] PORT_BP_HI = 8'h06;
    localparam logic [7:0] PORT_CLR   = 8'h07;
    // on-board memory map
    localparam logic [15:0] ROM_BASE  = 16'h0000;
    localparam logic [15:0] ROM_END   = 16'h0fff;
    localparam logic [15:0] EROM_BASE = 16'h1000;
    localparam logic [15:0] EROM_END  = 16'h13ff;
    localparam logic [15:0] RAM_BASE  = 16'h1400;
    localparam logic [15:0] RAM_END   = 16'h15ff;
    localparam int          RAM_BYTES = 512;
    localparam int          RAM_AW    = 9;
    // interrupt status / enable bit positions
    localparam int IRQ_RX   = 0;
    localparam int IRQ_TX   = 1;
    localparam int IRQ_KBD  = 2;
    localparam int IRQ_RTC  = 3;
    localparam int IRQ_EXT  = 4;
    localparam int IRQ_N    = 5;
    localparam int EN_W     = 4;
    // control port fields
    localparam int         BAUD_LSB = 4;
    localparam int         BAUD_W   = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // synchroniser lanes
    localparam int SY_KBD  = 0;
    localparam int SY_RX   = 1;
    localparam int SY_TX   = 2;
    localparam int SY_EXTN = 3;
    localparam int SY_HOLD = 4;
    localparam int SY_N    = 5;
    localparam logic [4:0] SY_RST = 5'h08;
    // real-time clock one-shot
    localparam int RTC_MS      = 10;
    localparam int CLK_KHZ     = 50000;
    localparam int RTC_CYCLES  = RTC_MS * CLK_KHZ;
    localparam int RTC_CNT_W   = 20;
    // restart opcode that enters the service routine at 56
    localparam logic [15:0] VEC_ADDR   = 16'h0038;
    localparam logic [7:0]  VEC_OPCODE = 8'hff;

    typedef enum logic [2:0] {
        SEL_NONE   = 3'b000,
        SEL_ROM    = 3'b001,
        SEL_EROM   = 3'b010,
        SEL_XCVR   = 3'b011,
        SEL_PANEL  = 3'b100,
        SEL_BPPORT = 3'b101,
        SEL_BPMEM  = 3'b110
    } tio_sel_type;

    typedef struct packed {
        tio_sel_type      sel;
        logic             rd;
        logic             wr;
        logic [15:0]      addr;
        logic [7:0]       wdata;
    } tio_ext_type;
endpackage : tio_pkg

// ==== hdl/tio_ram.sv ====
`timescale 1ns/100ps
module tio_ram #(
    parameter int AW    = 9,
    parameter int DEPTH = 512
) (
    input  wire logic          core_clk,
    input  wire logic          we,
    input  wire logic          hit,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    input  wire logic [7:0]    bypass,
    output logic      [7:0]    rdata_r
);
    logic [7:0] mem [DEPTH];

    // byte array write, read port registered; bypass loads when not a ram hit
    always_ff @(posedge core_clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata_r <= hit ? mem[addr] : bypass;
    end
endmodule : tio_ram

// ==== hdl/tio_rtc.sv ====
`timescale 1ns/100ps
module tio_rtc #(
    parameter int CYCLES = 500000,
    parameter int CW     = 20
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic trig,
    output logic      done_r
);
    typedef struct packed {
        logic          run;
        logic [CW-1:0] cnt;
        logic          done;
    } tio_rtc_state_type;

    tio_rtc_state_type st_r;
    tio_rtc_state_type st_nxt;

    // one-shot: trigger restarts the count, pulse when it runs out
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (trig)
        begin
            st_nxt.run = 1'b1;
            st_nxt.cnt = CW'(CYCLES - 1);
        end
        else if (st_r.run)
        begin
            if (st_r.cnt == '0)
            begin
                st_nxt.run  = 1'b0;
                st_nxt.done = 1'b1;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign done_r = st_r.done;
endmodule : tio_rtc

// ==== test/tio_top_properties.sv ====
`timescale 1ns/100ps
module tio_chk #(
    parameter int RTC_CYCLES = 20
) (
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    input wire logic [15:0]          bus_addr,
    input wire logic                 bus_io,
    input wire logic                 bus_inta,
    input wire logic [7:0]           bus_wdata,
    input wire logic                 bus_wr,
    input wire logic                 bus_rd,
    input wire logic [7:0]           bus_rdata,
    input wire logic                 irq,
    input wire logic                 cpu_hold,
    input wire logic [3:0]           baud_sel,
    input wire tio_pkg::tio_ext_type ext_cmd,
    input wire logic                 external_interrupt_request_n,
    input wire logic                 dma_hold_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // request kinds
    logic io_rd;
    logic io_wr;
    logic mem_rd;
    assign io_rd  = bus_rd && bus_io && !bus_inta;
    assign io_wr  = bus_wr && bus_io;
    assign mem_rd = bus_rd && !bus_io && !bus_inta;

    a_status_bits: assert property (io_rd && bus_addr[7:0] == 8'h01 |=>
        bus_rdata[7:5] == 3'h0)
        else $error("status upper bits not zero");
    a_baud_write: assert property (io_wr && bus_addr[7:0] == 8'h01 |=>
        baud_sel == $past(bus_wdata[7:4]))
        else $error("baud selection not taken");
    a_vector_ack: assert property (bus_rd && bus_inta |=> bus_rdata == 8'hff)
        else $error("acknowledge byte wrong");
    a_xcvr_select: assert property (io_rd && bus_addr[7:0] == 8'h00 |=>
        ext_cmd.rd && ext_cmd.sel == tio_pkg::SEL_XCVR)
        else $error("transceiver not selected");
    a_panel_write: assert property (io_wr && bus_addr[7:0] == 8'h03 |=> ext_cmd.wr &&
        ext_cmd.sel == tio_pkg::SEL_PANEL && ext_cmd.wdata == $past(bus_wdata))
        else $error("panel write wrong");
    a_bp_port: assert property ((io_rd || io_wr) && bus_addr[7:0] inside {[8'h04:8'h06]} |=>
        ext_cmd.sel == tio_pkg::SEL_BPPORT && ext_cmd.addr[7:0] == $past(bus_addr[7:0]))
        else $error("backplane port wrong");
    a_rom_decode: assert property (mem_rd && bus_addr <= 16'h0fff |=>
        ext_cmd.rd && ext_cmd.sel == tio_pkg::SEL_ROM)
        else $error("rom not selected");
    a_bp_memory: assert property (mem_rd && bus_addr > 16'h15ff |=>
        ext_cmd.sel == tio_pkg::SEL_BPMEM && ext_cmd.addr == $past(bus_addr))
        else $error("backplane memory wrong");
    a_ext_request: assert property (!external_interrupt_request_n [*8] |-> irq)
        else $error("external request lost");
    a_hold_follow: assert property (dma_hold_req [*6] |-> cpu_hold)
        else $error("processor not held");
endmodule : tio_chk

bind tio_top tio_chk #(.RTC_CYCLES(RTC_CYCLES)) i_chk (.core_clk, .rst_n, .bus_addr, .bus_io,
    .bus_inta, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq, .cpu_hold, .baud_sel, .ext_cmd,
    .external_interrupt_request_n, .dma_hold_req);

// ==== test/tio_far_model.sv ====
`timescale 1ns/100ps
// off-board ports and backplane memory
module tio_far_model (
    input  wire logic        core_clk,
    input  wire logic        bus_rd,
    input  wire logic [15:0] bus_addr,
    output logic      [7:0]  ext_rdata
);
    logic [7:0] noise_r = 8'h00;
    // bus left undriven outside reads shows a moving pattern
    always_ff @(posedge core_clk)
    begin
        noise_r <= noise_r + 8'h35;
    end
    assign ext_rdata = bus_rd ? (bus_addr[7:0] ^ bus_addr[15:8] ^ 8'h3c) : noise_r;
endmodule : tio_far_model

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic                 core_clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic [15:0]          bus_addr = 16'h0000;
    logic                 bus_io = 1'b0;
    logic                 bus_inta = 1'b0;
    logic [7:0]           bus_wdata = 8'h00;
    logic                 bus_wr = 1'b0;
    logic                 bus_rd = 1'b0;
    logic [7:0]           bus_rdata;
    logic                 irq;
    logic                 cpu_hold;
    logic [3:0]           baud_sel;
    tio_pkg::tio_ext_type ext_cmd;
    logic [7:0]           ext_rdata;
    logic [7:0]           kbd_data = 8'h00;
    logic                 kbd_strobe = 1'b0;
    logic                 xcvr_rx_ready = 1'b0;
    logic                 xcvr_tx_empty = 1'b0;
    logic                 external_interrupt_request_n = 1'b1;
    logic                 dma_hold_req = 1'b0;
    logic [7:0]           q;
    int                   bad_count = 0;
    int                   checks = 0;
    int                   cycles = 0;

    always #10 core_clk = ~core_clk;

    tio_top #(.RTC_CYCLES(20)) i_dut (.core_clk, .rst_n, .bus_addr, .bus_io, .bus_inta,
        .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq, .cpu_hold, .baud_sel, .ext_cmd,
        .ext_rdata, .kbd_data, .kbd_strobe, .xcvr_rx_ready, .xcvr_tx_empty,
        .external_interrupt_request_n, .dma_hold_req);
    tio_far_model i_far (.core_clk, .bus_rd, .bus_addr, .ext_rdata);

    task stop_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk

    // one bus cycle; q takes the byte of the following cycle
    task acc(input logic w, input logic io, input logic ia, input logic [15:0] a,
             input logic [7:0] d);
        @(posedge core_clk);
        bus_wr <= w;
        bus_rd <= !w;
        bus_io <= io;
        bus_inta <= ia;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        #1 q = bus_rdata;
    endtask : acc

    task pr(input logic [7:0] p);
        acc(1'b0, 1'b1, 1'b0, {8'h00, p}, 8'h00);
    endtask : pr

    task pw(input logic [7:0] p, input logic [7:0] d);
        acc(1'b1, 1'b1, 1'b0, {8'h00, p}, d);
    endtask : pw

    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            stop_test();
        end
    end

    // main sequence
    initial
    begin
        tick(8);
        rst_n <= 1'b1;
        tick(3);
        pr(8'h01);
        chk(q, 8'h00);
        tick(30);
        pr(8'h01);
        chk(q, 8'h08);
        chk(irq, 1'b0);
        pw(8'h01, 8'h58);
        tick(1);
        chk(irq, 1'b1);
        chk(baud_sel, 4'h5);
        pw(8'h07, 8'h08);
        pr(8'h01);
        chk(q, 8'h00);
        chk(irq, 1'b0);
        tick(12);
        pr(8'h01);
        chk(q, 8'h00);
        tick(10);
        pr(8'h01);
        chk(q, 8'h08);
        pw(8'h01, 8'h57);
        kbd_data <= 8'ha7;
        kbd_strobe <= 1'b1;
        tick(5);
        chk(irq, 1'b1);
        kbd_strobe <= 1'b0;
        pr(8'h01);
        chk(q & 8'h17, 8'h04);
        pr(8'h02);
        chk(q, 8'ha7);
        tick(1);
        chk(irq, 1'b0);
        xcvr_rx_ready <= 1'b1;
        xcvr_tx_empty <= 1'b1;
        tick(5);
        pr(8'h01);
        chk(q & 8'h17, 8'h03);
        pr(8'h00);
        chk(q, 8'h3c);
        chk({ext_cmd.sel, ext_cmd.rd}, {tio_pkg::SEL_XCVR, 1'b1});
        pr(8'h01);
        chk(q & 8'h17, 8'h02);
        pw(8'h00, 8'h41);
        pr(8'h01);
        chk(q & 8'h17, 8'h00);
        external_interrupt_request_n <= 1'b0;
        tick(8);
        chk(irq, 1'b1);
        pr(8'h01);
        chk(q & 8'h17, 8'h10);
        external_interrupt_request_n <= 1'b1;
        tick(4);
        pw(8'h07, 8'h10);
        tick(1);
        chk(irq, 1'b0);
        acc(1'b0, 1'b0, 1'b1, 16'h0000, 8'h00);
        chk(q, 8'hff);
        // off-board ports 3 to 6
        for (int p = 3; p < 7; p++)
        begin
            pw(p[7:0], 8'h90 + p[7:0]);
            chk(ext_cmd.sel, (p == 3) ? tio_pkg::SEL_PANEL : tio_pkg::SEL_BPPORT);
            chk({ext_cmd.wr, ext_cmd.wdata}, {1'b1, 8'h90 + p[7:0]});
        end
        acc(1'b1, 1'b0, 1'b0, 16'h1400, 8'ha5);
        acc(1'b1, 1'b0, 1'b0, 16'h15ff, 8'h5a);
        acc(1'b0, 1'b0, 1'b0, 16'h1400, 8'h00);
        chk(q, 8'ha5);
        acc(1'b0, 1'b0, 1'b0, 16'h15ff, 8'h00);
        chk(q, 8'h5a);
        acc(1'b0, 1'b0, 1'b0, 16'h0123, 8'h00);
        chk({ext_cmd.sel, q}, {tio_pkg::SEL_ROM, 8'h1e});
        acc(1'b0, 1'b0, 1'b0, 16'h13ff, 8'h00);
        chk(ext_cmd.sel, tio_pkg::SEL_EROM);
        acc(1'b0, 1'b0, 1'b0, 16'hffff, 8'h00);
        chk({ext_cmd.sel, q}, {tio_pkg::SEL_BPMEM, 8'h3c});
        dma_hold_req <= 1'b1;
        tick(8);
        chk(cpu_hold, 1'b1);
        dma_hold_req <= 1'b0;
        tick(4);
        chk(cpu_hold, 1'b0);
        // mid-run reset drops enables, baud and pending status
        pw(8'h01, 8'h5f);
        tick(1);
        chk(irq, 1'b1);
        rst_n <= 1'b0;
        tick(2);
        chk({irq, cpu_hold, baud_sel}, 6'h00);
        rst_n <= 1'b1;
        tick(3);
        pr(8'h01);
        chk(q, 8'h00);
        stop_test();
    end
endmodule : tb_top
